// ===== rtl/sspc_consts.vh
`ifndef SSPC_CONSTS_VH
`define SSPC_CONSTS_VH
// socket register space offsets (byte addresses)
`define SSPC_OFF_STATUS      12'h801
`define SSPC_OFF_POWER       12'h802
// legacy indexed offsets, first and second card
`define SSPC_IDX_STATUS_A    8'h01
`define SSPC_IDX_POWER_A     8'h02
`define SSPC_IDX_STATUS_B    8'h41
`define SSPC_IDX_POWER_B     8'h42
// power control field positions
`define SSPC_PWR_OE_BIT      7
`define SSPC_PWR_VCC_HI      4
`define SSPC_PWR_VCC_LO      3
`define SSPC_PWR_VPP_HI      1
`define SSPC_PWR_VPP_LO      0
// power control writable mask and reset value
`define SSPC_PWR_WMASK       8'h9b
`define SSPC_PWR_RESET       8'h00
// supply request codes
`define SSPC_VCC_OFF         2'h0
`define SSPC_VCC_RSVD        2'h1
`define SSPC_VCC_5V          2'h2
`define SSPC_VCC_3V          2'h3
// programming voltage request codes
`define SSPC_VPP_OFF         2'h0
`define SSPC_VPP_VCC         2'h1
`define SSPC_VPP_12V         2'h2
`define SSPC_VPP_RSVD        2'h3
// status field positions
`define SSPC_ST_PWR_BIT      6
`define SSPC_ST_RDY_BIT      5
`define SSPC_ST_WP_BIT       4
`define SSPC_ST_CD2_BIT      3
`define SSPC_ST_CD1_BIT      2
`endif

// ===== rtl/sspc_sync.v
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for a bundle of socket levels
module sspc_sync (
	// clock and reset
	input  wire       clk_i,
	input  wire       rstn_i,
	// levels
	input  wire [5:0] async_i,
	output reg  [5:0] sync_o
);
	reg [5:0] stage1;   // first stage, read only by second

	////////////////////////////////////////////////////////////////
	// per-bit double flop
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_bit
			always @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					stage1[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end else begin
					stage1[g] <= async_i[g];
					sync_o[g] <= stage1[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== rtl/sspc_power_decode.v
`timescale 1ns/10ps
`default_nettype none
`include "sspc_consts.vh"
// decodes power control requests into switch enables
module sspc_power_decode (
	// request fields
	input  wire [1:0] vcc_req_i,
	input  wire [1:0] vpp_req_i,
	// decoded enables
	output reg        vcc_5v_o,
	output reg        vcc_3v_o,
	output reg        vpp_vcc_o,
	output reg        vpp_12v_o
);
	reg vcc_on;   // supply enabled at 5 V or 3.3 V

	////////////////////////////////////////////////////////////////
	// combinational decode
	always @* begin
		vcc_5v_o  = (vcc_req_i == `SSPC_VCC_5V);
		vcc_3v_o  = (vcc_req_i == `SSPC_VCC_3V);
		vcc_on    = vcc_5v_o | vcc_3v_o;
		// vpp request only honoured while supply is on
		vpp_vcc_o = vcc_on & (vpp_req_i == `SSPC_VPP_VCC);
		vpp_12v_o = vcc_on & (vpp_req_i == `SSPC_VPP_12V);
	end
endmodule
`default_nettype wire

// ===== rtl/sspc_socket_regs.v
// How it works
// - status bit 7 reads zero always
// - status bit 6 shows power on
// - status bit 5 shows card ready
// - status bit 4 mirrors write protect
// - bits 3,2 show inverted detect pins
// - memory card: bits 1,0 battery detect
// - io card: bits 1,0 speaker, change
// - status bit 7 zero, bit 6 power, low six bits live
// - control bit 7 gates card outputs
// - control bits 6,5,2 read zero
// - supply field 4:3 decoded to voltages
// - programming field 1:0 decoded to voltages
// - programming ignored unless supply enabled
// - control at 802h and legacy index
`timescale 1ns/10ps
`default_nettype none
`include "sspc_consts.vh"
module sspc_socket_regs (
	// clock and reset
	input  wire       sys_clk_i,
	input  wire       rstn_i,
	// register access
	input  wire       reg_sel_i,       // access strobe, one cycle
	input  wire       reg_wr_i,        // 1 write, 0 read
	input  wire       legacy_i,        // 1 legacy index, 0 socket space
	input  wire       socket_b_i,      // legacy only: second card
	input  wire [11:0] reg_addr_i,     // byte offset or index
	input  wire [7:0] reg_wdata_i,
	output reg  [7:0] reg_rdata_o,
	output reg        reg_ack_o,
	// card socket levels
	input  wire       card_ready_i,
	input  wire       card_wp_i,
	input  wire       card_cd1_n_i,
	input  wire       card_cd2_n_i,
	input  wire       card_bvd1_i,     // battery detect 1 or speaker
	input  wire       card_bvd2_i,     // battery detect 2 or status change
	// socket control
	output wire       socket_output_enable_o,
	output wire       vcc_5v_o,
	output wire       vcc_3v_o,
	output wire       vpp_vcc_o,
	output wire       vpp_12v_o,
	output wire       socket_power_state_o
);
	reg        rst_ff1;                // reset release stage 1
	reg        rst_ff2;                // reset release stage 2
	wire       rst_n;                  // synchronised reset
	reg  [7:0] socket_power_control;   // stored control register
	wire [5:0] live;                   // synchronised socket levels
	wire [7:0] socket_interface_status;
	wire [1:0] supply_voltage_request;
	wire [1:0] program_voltage_request;
	wire       hit_status;
	wire       hit_power;
	wire [7:0] idx_status;
	wire [7:0] idx_power;
	wire       p_5v;
	wire       p_3v;
	wire       p_vv;
	wire       p_12;

	////////////////////////////////////////////////////////////////
	// reset release through two flops
	always @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_ff1 <= 1'b0;
			rst_ff2 <= 1'b0;
		end else begin
			rst_ff1 <= 1'b1;
			rst_ff2 <= rst_ff1;
		end
	end
	assign rst_n = rst_ff2;

	////////////////////////////////////////////////////////////////
	// socket input synchroniser
	sspc_sync u_sync (
		.clk_i   (sys_clk_i),
		.rstn_i  (rst_n),
		.async_i ({card_ready_i, card_wp_i, card_cd2_n_i, card_cd1_n_i,
		           card_bvd1_i, card_bvd2_i}),
		.sync_o  (live)
	);

	////////////////////////////////////////////////////////////////
	// address decode
	assign idx_status = socket_b_i ? `SSPC_IDX_STATUS_B : `SSPC_IDX_STATUS_A;
	assign idx_power  = socket_b_i ? `SSPC_IDX_POWER_B  : `SSPC_IDX_POWER_A;
	assign hit_status = legacy_i ? (reg_addr_i[7:0] == idx_status && reg_addr_i[11:8] == 4'h0)
	                             : (reg_addr_i == `SSPC_OFF_STATUS);
	assign hit_power  = legacy_i ? (reg_addr_i[7:0] == idx_power && reg_addr_i[11:8] == 4'h0)
	                             : (reg_addr_i == `SSPC_OFF_POWER);

	////////////////////////////////////////////////////////////////
	// power control register, reserved bits never stored
	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			socket_power_control <= `SSPC_PWR_RESET;
		end else if (reg_sel_i && reg_wr_i && hit_power) begin
			socket_power_control <= reg_wdata_i & `SSPC_PWR_WMASK;
		end
	end

	assign supply_voltage_request  = socket_power_control[`SSPC_PWR_VCC_HI:`SSPC_PWR_VCC_LO];
	assign program_voltage_request = socket_power_control[`SSPC_PWR_VPP_HI:`SSPC_PWR_VPP_LO];
	assign socket_output_enable_o  = socket_power_control[`SSPC_PWR_OE_BIT];

	////////////////////////////////////////////////////////////////
	// voltage decode
	sspc_power_decode u_dec (
		.vcc_req_i (supply_voltage_request),
		.vpp_req_i (program_voltage_request),
		.vcc_5v_o  (p_5v),
		.vcc_3v_o  (p_3v),
		.vpp_vcc_o (p_vv),
		.vpp_12v_o (p_12)
	);
	assign vcc_5v_o  = p_5v;
	assign vcc_3v_o  = p_3v;
	assign vpp_vcc_o = p_vv;
	assign vpp_12v_o = p_12;
	// power on when supply switched on by the control register
	assign socket_power_state_o = p_5v | p_3v;

	////////////////////////////////////////////////////////////////
	// status image: bvd pins carry speaker/change for io cards as-is
	assign socket_interface_status = {
		1'b0,
		socket_power_state_o,
		live[5],
		live[4],
		~live[3],
		~live[2],
		live[1],
		live[0]
	};

	////////////////////////////////////////////////////////////////
	// read data and acknowledge, one cycle after strobe
	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 8'h00;
			reg_ack_o   <= 1'b0;
		end else begin
			reg_ack_o <= reg_sel_i;
			if (reg_sel_i && !reg_wr_i) begin
				if (hit_status) begin
					reg_rdata_o <= socket_interface_status;
				end else if (hit_power) begin
					reg_rdata_o <= socket_power_control;
				end else begin
					reg_rdata_o <= 8'h00;   // unmapped reads zero
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/sspc_card_model.sv
`timescale 1ns/10ps
`default_nettype none
// card model: unseated signal lines float to their pull-ups
module sspc_card_model (
	input  wire logic [1:0] ins_i,
	input  wire logic [3:0] lvl_i,
	output wire logic       card_ready_o, card_wp_o, card_bvd1_o, card_bvd2_o,
	output wire logic       card_cd1_n_o, card_cd2_n_o
);
	assign {card_cd2_n_o, card_cd1_n_o} = ~ins_i;
	assign {card_ready_o, card_wp_o, card_bvd1_o, card_bvd2_o} = (|ins_i) ? lvl_i : 4'hf;
endmodule
`default_nettype wire

// ===== verif/sspc_socket_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sspc_regs_chk (
	input wire logic        sys_clk_i, rstn_i, reg_sel_i, reg_wr_i, legacy_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0]  reg_wdata_i, reg_rdata_o,
	input wire logic        reg_ack_o, socket_output_enable_o, vcc_5v_o, vcc_3v_o,
	input wire logic        vpp_vcc_o, vpp_12v_o, socket_power_state_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// decoded socket space accesses
	wire rd_st = reg_sel_i && !reg_wr_i && !legacy_i && reg_addr_i == 12'h801;
	wire rd_pc = reg_sel_i && !reg_wr_i && !legacy_i && reg_addr_i == 12'h802;
	wire wr_pc = reg_sel_i && reg_wr_i && !legacy_i && reg_addr_i == 12'h802;
	property p_ack; reg_sel_i |=> reg_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing after strobe");
	property p_nak; !reg_sel_i |=> !reg_ack_o; endproperty
	a_nak: assert property (p_nak) else $error("ack without strobe");
	property p_st; rd_st |=> reg_rdata_o[7:6] == {1'b0, $past(socket_power_state_o)}; endproperty
	a_st: assert property (p_st) else $error("status top bits wrong");
	property p_pwr; socket_power_state_o == (vcc_5v_o | vcc_3v_o); endproperty
	a_pwr: assert property (p_pwr) else $error("power state wrong");
	property p_vpp; (vpp_vcc_o | vpp_12v_o) |-> socket_power_state_o; endproperty
	a_vpp: assert property (p_vpp) else $error("vpp without supply");
	property p_one; !(vcc_5v_o && vcc_3v_o) && !(vpp_vcc_o && vpp_12v_o); endproperty
	a_one: assert property (p_one) else $error("two voltages at once");
	property p_oe; wr_pc |=> socket_output_enable_o == $past(reg_wdata_i[7]); endproperty
	a_oe: assert property (p_oe) else $error("output enable wrong");
	property p_vcc; wr_pc |=> {vcc_5v_o, vcc_3v_o} == {$past(reg_wdata_i[4:3]) == 2'h2,
		$past(reg_wdata_i[4:3]) == 2'h3}; endproperty
	a_vcc: assert property (p_vcc) else $error("supply decode wrong");
	property p_rsv; rd_pc |=> reg_rdata_o[6:5] == 2'h0 && !reg_rdata_o[2]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule
bind sspc_socket_regs sspc_regs_chk chk_u (.sys_clk_i, .rstn_i, .reg_sel_i, .reg_wr_i,
	.legacy_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .socket_output_enable_o,
	.vcc_5v_o, .vcc_3v_o, .vpp_vcc_o, .vpp_12v_o, .socket_power_state_o);
`default_nettype wire

// ===== verif/test_sspc_socket_regs.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module test_sspc_socket_regs;
	logic clk = 0, rstn = 0, sel = 0, wr = 0, leg = 0, sb = 0, pw = 0;
	logic [11:0] addr = 0;
	logic [7:0] wd = 0, q;
	logic [1:0] ins = 0;
	logic [3:0] lvl = 0;
	wire [7:0] rd;
	wire ack, oe, v5, v3, pv, p12, ps, rdy, wp, b1, b2, c1n, c2n;
	int miscompares = 0, total_checks = 0, cyc = 0;
	sspc_card_model card_u (.ins_i(ins), .lvl_i(lvl), .card_ready_o(rdy), .card_wp_o(wp),
		.card_bvd1_o(b1), .card_bvd2_o(b2), .card_cd1_n_o(c1n), .card_cd2_n_o(c2n));
	sspc_socket_regs dut_u (.sys_clk_i(clk), .rstn_i(rstn), .reg_sel_i(sel), .reg_wr_i(wr),
		.legacy_i(leg), .socket_b_i(sb), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_rdata_o(rd), .reg_ack_o(ack), .card_ready_i(rdy), .card_wp_i(wp),
		.card_cd1_n_i(c1n), .card_cd2_n_i(c2n), .card_bvd1_i(b1), .card_bvd2_i(b2),
		.socket_output_enable_o(oe), .vcc_5v_o(v5), .vcc_3v_o(v3), .vpp_vcc_o(pv),
		.vpp_12v_o(p12), .socket_power_state_o(ps));
	initial forever #50 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// one strobe, inputs change on the falling edge
	task automatic acc(input logic w, l, b, input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		{sel, wr, leg, sb, addr, wd} = {1'b1, w, l, b, a, d};
		@(negedge clk);
		sel = 0;
		`CHK("ack", 1'b1, ack)
		q = rd;
	endtask
	task automatic t_reset;
		acc(0, 0, 0, 12'h802, 0);
		`CHK("ctl rst", 8'h00, q)
		acc(0, 0, 0, 12'h801, 0);
		`CHK("st rst", 2'h0, q[7:6])
	endtask
	task automatic t_power;
		logic [7:0] d;
		for (int i = 0; i < 16; i++) begin
			d = {i[0], 2'b11, i[3:2], 1'b1, i[1:0]};
			acc(1, 0, 0, 12'h802, d);
			acc(0, 0, 0, 12'h802, 0);
			`CHK("ctl", d & 8'h9b, q)
			`CHK("oe", d[7], oe)
			`CHK("vcc", {d[4:3] == 2'h2, d[4:3] == 2'h3}, {v5, v3})
			`CHK("vpp", {i[3] && d[1:0] == 2'h1, i[3] && d[1:0] == 2'h2}, {pv, p12})
			`CHK("pwr", d[4], ps)
		end
	endtask
	task automatic t_status;
		acc(1, 0, 0, 12'h802, 8'h98);
		for (int i = 0; i < 64; i++) begin
			{ins, lvl} = i[5:0];
			repeat (3) @(negedge clk);
			acc(0, 0, 0, 12'h801, 0);
			`CHK("st", {2'b01, rdy, wp, ~c2n, ~c1n, b1, b2}, q)
		end
	endtask
	task automatic t_map;
		acc(1, 1, 0, 12'h002, 8'h9a);
		acc(0, 0, 0, 12'h802, 0);
		`CHK("idx a", 8'h9a, q)
		acc(1, 1, 1, 12'h042, 8'h13);
		acc(0, 1, 0, 12'h002, 0);
		`CHK("idx b", 8'h13, q)
		acc(0, 1, 1, 12'h041, 0);
		`CHK("idx st b", 8'h7f, q)
		acc(1, 0, 0, 12'h801, 8'hff);
		acc(0, 0, 0, 12'h801, 0);
		`CHK("st b7", 1'b0, q[7])
		acc(0, 0, 0, 12'h803, 0);
		`CHK("unmapped", 8'h00, q)
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rstn = 1;
		repeat (3) @(negedge clk);
		t_reset;
		t_power;
		t_status;
		t_map;
		stop_test;
	end
endmodule
`default_nettype wire
